/* hw/ecb_pkg.sv */
// Constants and types shared by the external bus controller.
// Assumes one processor clock; no file-level state.
package ecb_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // ----------------------------------------
    // Operand and port sizes in bytes
    // ----------------------------------------
    localparam logic [1:0] SZ_LONG = 2'h0;
    localparam logic [2:0] BYTES_LONG = 3'h4;
    localparam logic [2:0] BYTES_WORD = 3'h2;
    localparam logic [2:0] BYTES_BYTE = 3'h1;
    localparam logic [2:0] BYTES_NONE = 3'h0;

    // ----------------------------------------
    // Port width acknowledge, asserted form {ack1, ack0}
    // ----------------------------------------
    localparam logic [1:0] ACK_NONE = 2'h0;
    localparam logic [1:0] ACK_P8 = 2'h1;
    localparam logic [1:0] ACK_P16 = 2'h2;
    localparam logic [1:0] ACK_P32 = 2'h3;

    // ----------------------------------------
    // Burst line and cycle timing
    // ----------------------------------------
    localparam logic [1:0] FIRST_BEAT = 2'h0;
    localparam logic [1:0] SECOND_BEAT = 2'h1;
    localparam logic [1:0] LAST_BEAT = 2'h3;
    localparam logic [3:0] ASYNC_MIN_WAIT = 4'h2;
    localparam logic [3:0] SYNC_MIN_WAIT = 4'h1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_WAIT,
        ST_BURST,
        ST_HOLD
    } ecb_state_t;

endpackage

/* hw/ecb_bus_ctrl.sv */
// External bus controller: core operand requests to an asynchronous,
// synchronous and burst external bus with dynamic bus sizing.
// Assumes all bus inputs are already synchronous to CLK_I.
`timescale 1ns/100ps

// What this block does
// - Asynchronous cycle takes three clocks minimum
// - Sync end means 32 bits, two clocks
// - Burst takes a long word each sync end
// - Split operand to fit 8/16/32 ports
// - Long read tries 32 bits first
// - Each port width owns fixed lanes
// - Any alignment, minimum number of cycles
// - Instruction fetch must be word aligned
// - Early acknowledge ends cycle in three clocks
// - Fault aborts; fault with halt reruns
// - Sync end unsynchronised, two clock cycle
// - Sync cycle: fault aborts, with halt retries
// - Burst only when requested and synchronous
// - Burst holds strobes, address, size steady
// - Burst ends: full, fault, no-cache, no grant
// - Line is four long words, four beats
// - Sync end implies 32-bit port, latch data
// - Size outputs give bytes still to move
// - Cycle start each cycle, operand start on first cycle and its rerun
module ecb_bus_ctrl (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic REQ_VALID_I,
    input wire logic [ecb_pkg::ADDR_W-1:0] REQ_ADDR_I,
    input wire logic [1:0] REQ_SIZE_I,
    input wire logic REQ_WRITE_I,
    input wire logic [ecb_pkg::DATA_W-1:0] REQ_WDATA_I,
    input wire logic [2:0] REQ_FC_I,
    input wire logic REQ_FILL_I,
    input wire logic REQ_NOCACHE_I,
    input wire logic REQ_IFETCH_I,
    output logic REQ_READY_O,
    output logic DONE_O,
    output logic FAULT_O,
    output logic ALIGN_ERR_O,
    output logic [ecb_pkg::DATA_W-1:0] RDATA_O,
    output logic FILL_VALID_O,
    output logic [ecb_pkg::DATA_W-1:0] FILL_DATA_O,
    output logic [1:0] FILL_IDX_O,
    output logic [ecb_pkg::ADDR_W-1:0] ADDR_O,
    output logic [2:0] FC_O,
    output logic [1:0] TRANSFER_SIZE_O,
    output logic RW_O,
    output logic ADDRESS_STROBE_N_O,
    output logic DATA_STROBE_N_O,
    output logic CYCLE_START_EARLY_N_O,
    output logic FIRST_OPERAND_CYCLE_START_N_O,
    output logic LINE_FILL_REQUEST_N_O,
    output logic [ecb_pkg::DATA_W-1:0] DATA_O,
    output logic DATA_OE_N_O,
    input wire logic [ecb_pkg::DATA_W-1:0] DATA_I,
    input wire logic [1:0] PORT_WIDTH_ACK_N_I,
    input wire logic SYNC_CYCLE_END_N_I,
    input wire logic BUS_FAULT_N_I,
    input wire logic HALT_N_I,
    input wire logic LINE_FILL_GRANT_N_I,
    input wire logic NO_CACHE_IN_N_I
);
    import ecb_pkg::*;

    // ----------------------------------------
    // Lane functions
    // ----------------------------------------
    function automatic logic [1:0] lane_start(input logic [2:0] pb, input logic [1:0] a);
        lane_start = (pb == BYTES_LONG) ? a : ((pb == BYTES_WORD) ? {1'b0, a[0]} : 2'h0);
    endfunction

    // Pick n bytes starting at lane s (lane 0 is the top byte), right-justified
    function automatic logic [31:0] extract(input logic [31:0] d, input logic [1:0] s,
                                            input logic [2:0] n);
        logic [31:0] t;
        t = d << {s, 3'h0};
        extract = t >> {BYTES_LONG - n, 3'h0};
    endfunction

    // Copies the next operand bytes onto every lane a narrow port might use,
    // so the write data is right whatever width the slave turns out to be
    function automatic logic [31:0] wr_lanes(input logic [31:0] w, input logic [1:0] a);
        logic [31:0] t;
        t = w >> {a, 3'h0};
        wr_lanes = {w[31:24], a[0] ? w[31:24] : w[23:16],
                    a[1] ? w[31:24] : (a[0] ? w[23:16] : w[15:8]), t[7:0]};
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    ecb_state_t state_q, state_d;
    logic [31:0] addr_q, addr_d, wl_q, wl_d, acc_q, acc_d;
    logic [2:0] rem_q, rem_d, fc_q;
    logic [1:0] beat_q, beat_d;
    logic wr_q, wr_d, first_q, first_d, fill_q, fill_d, saw_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire sync_end = ~SYNC_CYCLE_END_N_I;
    wire fault = ~BUS_FAULT_N_I;
    wire halt = ~HALT_N_I;
    wire grant = ~LINE_FILL_GRANT_N_I;
    wire nci = ~NO_CACHE_IN_N_I;
    wire [1:0] ack_a = ~PORT_WIDTH_ACK_N_I;
    // Sync end overrides the width code: it is always a 32-bit port
    wire [2:0] port_b = sync_end ? BYTES_LONG : (ack_a == ACK_P32) ? BYTES_LONG :
                        (ack_a == ACK_P16) ? BYTES_WORD : BYTES_BYTE;
    wire [1:0] lane0 = lane_start(port_b, addr_q[1:0]);
    wire [2:0] room = port_b - {1'b0, lane0};
    wire [2:0] take = (rem_q < room) ? rem_q : room;
    wire [2:0] rem_left = rem_q - take;
    wire [31:0] rd_bytes = extract(DATA_I, lane0, take);
    wire in_wait = state_q == ST_WAIT;
    wire in_burst = state_q == ST_BURST;
    wire retry = in_wait && fault && halt;
    wire abort = in_wait && fault && !halt;
    // Width ack counts only from the second wait clock; sync end from the first
    wire acc_ok = in_wait && !fault && (sync_end || (ack_a != ACK_NONE && saw_q));
    wire go_burst = acc_ok && sync_end && fill_q && grant;
    wire b_stop = fault || nci || !grant;
    wire b_beat = in_burst && !b_stop && sync_end;
    wire b_end = in_burst && (b_stop || (b_beat && beat_q == LAST_BEAT));
    // Ready gates the take so a request in the first clock after reset is refused
    wire take_req = state_q == ST_IDLE && REQ_VALID_I && REQ_READY_O;
    wire bad_fetch = take_req && REQ_IFETCH_I && REQ_ADDR_I[0];
    wire [2:0] req_bytes = (REQ_SIZE_I == SZ_LONG) ? BYTES_LONG : {1'b0, REQ_SIZE_I};
    wire fill_ok = REQ_FILL_I && !REQ_WRITE_I && !REQ_NOCACHE_I &&
                   req_bytes == BYTES_LONG && REQ_ADDR_I[1:0] == 2'h0;
    wire op_done = (acc_ok && !go_burst && rem_left == BYTES_NONE) || b_end;
    wire bus_act_d = state_d == ST_WAIT || state_d == ST_BURST;
    wire start_d = state_d == ST_START;
    wire drive_d = wr_d && (start_d || state_d == ST_WAIT);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        rem_d = rem_q;
        wl_d = wl_q;
        acc_d = acc_q;
        wr_d = wr_q;
        first_d = first_q;
        fill_d = fill_q;
        beat_d = beat_q;
        case (state_q)
            ST_IDLE: begin
                if (take_req && !bad_fetch) begin
                    state_d = ST_START;
                    addr_d = REQ_ADDR_I;
                    rem_d = req_bytes;
                    // Left-justify so the next byte to send is always the top one
                    wl_d = REQ_WDATA_I << {BYTES_LONG - req_bytes, 3'h0};
                    acc_d = 32'h0;
                    wr_d = REQ_WRITE_I;
                    first_d = 1'b1;
                    fill_d = fill_ok;
                end
            end
            ST_START: begin
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (retry) begin
                    state_d = ST_HOLD;
                end else if (abort) begin
                    state_d = ST_IDLE;
                    fill_d = 1'b0;
                end else if (acc_ok) begin
                    // Burst keeps address and size of the first beat on the pins
                    addr_d = go_burst ? addr_q : addr_q + 32'(take);
                    rem_d = go_burst ? rem_q : rem_left;
                    wl_d = wl_q << {take, 3'h0};
                    acc_d = (acc_q << {take, 3'h0}) | rd_bytes;
                    first_d = 1'b0;
                    if (go_burst) begin
                        state_d = ST_BURST;
                        beat_d = SECOND_BEAT;
                    end else if (rem_left == BYTES_NONE) begin
                        state_d = ST_IDLE;
                        fill_d = 1'b0;
                    end else begin
                        state_d = ST_START;
                    end
                end
            end
            ST_BURST: begin
                if (b_beat) begin
                    beat_d = beat_q + 2'h1;
                end
                if (b_end) begin
                    state_d = ST_IDLE;
                    fill_d = 1'b0;
                end
            end
            ST_HOLD: begin
                // Rerun the same cycle once halt is released
                if (!halt) begin
                    state_d = ST_START;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
            addr_q <= 32'h0;
            rem_q <= BYTES_NONE;
            wl_q <= 32'h0;
            acc_q <= 32'h0;
            wr_q <= 1'b0;
            first_q <= 1'b0;
            fill_q <= 1'b0;
            beat_q <= FIRST_BEAT;
            saw_q <= 1'b0;
            fc_q <= 3'h0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            rem_q <= rem_d;
            wl_q <= wl_d;
            acc_q <= acc_d;
            wr_q <= wr_d;
            first_q <= first_d;
            fill_q <= fill_d;
            beat_q <= beat_d;
            saw_q <= in_wait;
            fc_q <= take_req ? REQ_FC_I : fc_q;
        end
    end

    // ----------------------------------------
    // Pin and core outputs, all registered
    // ----------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ADDRESS_STROBE_N_O <= 1'b1;
            DATA_STROBE_N_O <= 1'b1;
            CYCLE_START_EARLY_N_O <= 1'b1;
            FIRST_OPERAND_CYCLE_START_N_O <= 1'b1;
            LINE_FILL_REQUEST_N_O <= 1'b1;
            RW_O <= 1'b1;
            DATA_OE_N_O <= 1'b1;
            DATA_O <= 32'h0;
            REQ_READY_O <= 1'b0;
            DONE_O <= 1'b0;
            FAULT_O <= 1'b0;
            ALIGN_ERR_O <= 1'b0;
            RDATA_O <= 32'h0;
            FILL_VALID_O <= 1'b0;
            FILL_DATA_O <= 32'h0;
            FILL_IDX_O <= FIRST_BEAT;
        end else begin
            ADDRESS_STROBE_N_O <= !bus_act_d;
            DATA_STROBE_N_O <= !bus_act_d;
            CYCLE_START_EARLY_N_O <= !start_d;
            FIRST_OPERAND_CYCLE_START_N_O <= !(start_d && first_d);
            LINE_FILL_REQUEST_N_O <= !(fill_d && state_d != ST_IDLE);
            RW_O <= !wr_d;
            DATA_OE_N_O <= !drive_d;
            DATA_O <= wr_lanes(wl_d, addr_d[1:0]);
            REQ_READY_O <= state_d == ST_IDLE;
            DONE_O <= op_done;
            FAULT_O <= abort;
            ALIGN_ERR_O <= bad_fetch;
            RDATA_O <= op_done ? acc_d : RDATA_O;
            FILL_VALID_O <= go_burst || b_beat;
            FILL_DATA_O <= DATA_I;
            FILL_IDX_O <= go_burst ? FIRST_BEAT : beat_q;
        end
    end

    assign ADDR_O = addr_q;
    assign FC_O = fc_q;
    assign TRANSFER_SIZE_O = rem_q[1:0];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [3:0] cyc_q;
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cyc_q <= 4'h0;
        end else if (state_q == ST_START) begin
            cyc_q <= 4'h1;
        end else if (in_wait && cyc_q != 4'hf) begin
            cyc_q <= cyc_q + 4'h1;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    AST_ASYNC_MIN: assert property (acc_ok && !sync_end |-> cyc_q >= ASYNC_MIN_WAIT)
        else $error("asynchronous cycle ended before three clocks");
    AST_SYNC_MIN: assert property (acc_ok && sync_end |-> cyc_q >= SYNC_MIN_WAIT
        && (take == rem_q || take == BYTES_LONG - {1'b0, addr_q[1:0]}))
        else $error("synchronous cycle too short or not full width");
    AST_SPLIT: assert property (acc_ok && !go_burst && rem_left != BYTES_NONE
        |=> state_q == ST_START && rem_q == $past(rem_q) - $past(take))
        else $error("remaining operand not rerun in next cycle");
    AST_LANE8: assert property (acc_ok && !sync_end && ack_a == ACK_P8 && !wr_q
        |=> acc_q[7:0] == $past(DATA_I[31:24]))
        else $error("8-bit port byte not taken from top lane");
    AST_ALIGN: assert property (bad_fetch |=> ALIGN_ERR_O && state_q == ST_IDLE && ADDRESS_STROBE_N_O)
        else $error("odd fetch address started a bus cycle");
    AST_ABORT: assert property (abort |=> FAULT_O && state_q == ST_IDLE ##1 ADDRESS_STROBE_N_O)
        else $error("bus fault did not abort the cycle");
    AST_RETRY: assert property (retry ##1 !halt |=> state_q == ST_START && $stable(addr_q))
        else $error("fault with halt did not rerun the cycle");
    AST_BURST_REQ: assert property (go_burst |-> !LINE_FILL_REQUEST_N_O)
        else $error("burst entered without line fill request");
    AST_BURST_HOLD: assert property (in_burst && !b_end |=> $stable(ADDR_O) && $stable(TRANSFER_SIZE_O)
        && !ADDRESS_STROBE_N_O && RW_O)
        else $error("burst outputs moved");
    AST_BURST_BEAT: assert property (b_beat |=> FILL_VALID_O && FILL_DATA_O == $past(DATA_I))
        else $error("burst beat not latched");
    AST_BURST_END: assert property (in_burst && (nci || !grant || fault) |=> state_q == ST_IDLE)
        else $error("burst did not stop");
    AST_BURST_FOUR: assert property (in_burst |-> beat_q != FIRST_BEAT)
        else $error("burst beat count wrapped");
    AST_OCS: assert property (!FIRST_OPERAND_CYCLE_START_N_O |-> !CYCLE_START_EARLY_N_O)
        else $error("operand start without cycle start");
    AST_FILL_READ: assert property (!LINE_FILL_REQUEST_N_O |-> RW_O)
        else $error("line fill request on a write");

    COV_FULL_BURST: cover property (b_beat && beat_q == LAST_BEAT);
    COV_RETRY: cover property (retry ##[1:20] acc_ok);
    COV_BYTE_LONG: cover property (acc_ok && ack_a == ACK_P8 && !sync_end ##[1:20] op_done);
    COV_MISALIGNED_WRITE: cover property (acc_ok && wr_q && addr_q[1:0] == 2'h3);
endmodule

/* dv/ecb_slave_model.sv */
// Behavioural memory slave on the far side of the external bus controller.
// Assumes the bench changes the mode inputs only while the bus is idle.
`timescale 1ns/100ps
module ecb_slave_model (
    input wire logic clk_i,
    input wire logic [31:0] addr_i,
    input wire logic as_n_i,
    input wire logic [1:0] p_ack_n_i,
    input wire logic p_sync_i,
    input wire logic [3:0] p_wait_i,
    input wire logic [3:0] p_gnt_i,
    input wire logic p_nc_i,
    input wire logic [1:0] p_fault_i,
    output logic [31:0] data_o,
    output logic [1:0] ack_n_o,
    output logic sync_n_o,
    output logic fault_n_o,
    output logic halt_n_o,
    output logic gnt_n_o,
    output logic nc_n_o
);
    logic [3:0] cnt = 4'h0;
    logic [7:0] cyc = 8'h0;
    logic used = 1'b0;
    logic [31:0] a;
    logic [31:0] w;
    initial begin
        {data_o, ack_n_o, sync_n_o, fault_n_o, halt_n_o, gnt_n_o, nc_n_o} = '1;
    end
    // ----------------------------------------
    // Response, one step after each edge
    // ----------------------------------------
    always @(posedge clk_i) begin
        #1;
        cyc = cyc + 8'h1;
        // Released lanes toggle every cycle so stale data cannot pass
        data_o = {4{cyc}} ^ 32'h3c96a55a;
        {ack_n_o, sync_n_o, fault_n_o, halt_n_o, gnt_n_o, nc_n_o} = '1;
        if (p_fault_i == 2'h0) used = 1'b0;
        if (!as_n_i) begin
            if (cnt >= p_wait_i) begin
                if (p_fault_i != 2'h0 && !used) begin
                    fault_n_o = 1'b0;
                    halt_n_o = (p_fault_i != 2'h2);
                    used = 1'b1;
                end else if (p_sync_i) begin
                    sync_n_o = 1'b0;
                end else begin
                    ack_n_o = p_ack_n_i;
                end
                a = (p_gnt_i != 4'h0) ? addr_i + {cnt, 2'h0} : addr_i;
                if (p_sync_i || p_ack_n_i == 2'h0) a[1:0] = 2'h0;
                if (!p_sync_i && p_ack_n_i == 2'h1) a[0] = 1'b0;
                w = {a[7:0], a[7:0] + 8'h1, a[7:0] + 8'h2, a[7:0] + 8'h3};
                // Each port width owns fixed lanes from the top
                if (p_sync_i || p_ack_n_i == 2'h0) data_o = w;
                else if (p_ack_n_i == 2'h1) data_o[31:16] = w[31:16];
                else data_o[31:24] = w[31:24];
                gnt_n_o = (p_gnt_i == 4'h0) || (!p_nc_i && cnt >= p_gnt_i);
                nc_n_o = !(p_nc_i && cnt >= p_gnt_i);
            end
            cnt = cnt + 4'h1;
        end else begin
            cnt = 4'h0;
        end
    end
endmodule

/* dv/testbench.sv */
// Self-checking bench for the external bus controller.
// Assumes the slave model answers on the bus side.
`timescale 1ns/100ps
module testbench;
    import ecb_pkg::*;
    logic CLK_I = 0, RST_N_I = 0, REQ_VALID_I = 0, REQ_WRITE_I = 0;
    logic REQ_FILL_I = 0, REQ_NOCACHE_I = 0, REQ_IFETCH_I = 0;
    logic [ADDR_W-1:0] REQ_ADDR_I = '0;
    logic [DATA_W-1:0] REQ_WDATA_I = '0;
    logic [1:0] REQ_SIZE_I = '0;
    logic [2:0] REQ_FC_I = 3'h5;
    logic REQ_READY_O, DONE_O, FAULT_O, ALIGN_ERR_O, FILL_VALID_O, RW_O;
    logic [DATA_W-1:0] RDATA_O, FILL_DATA_O, DATA_O, DATA_I;
    logic [ADDR_W-1:0] ADDR_O;
    logic [1:0] FILL_IDX_O, TRANSFER_SIZE_O, PORT_WIDTH_ACK_N_I;
    logic [2:0] FC_O;
    logic ADDRESS_STROBE_N_O, DATA_STROBE_N_O, CYCLE_START_EARLY_N_O, DATA_OE_N_O;
    logic FIRST_OPERAND_CYCLE_START_N_O, LINE_FILL_REQUEST_N_O, SYNC_CYCLE_END_N_I;
    logic BUS_FAULT_N_I, HALT_N_I, LINE_FILL_GRANT_N_I, NO_CACHE_IN_N_I;
    logic [1:0] p_ack = 2'h3, p_fault = 2'h0;
    logic [3:0] p_wait = 4'h1, p_gnt = 4'h0;
    logic p_sync = 0, p_nc = 0, lfr_seen = 0, as_q = 1;
    int n_fail = 0, tests_run = 0, cycles = 0, n_ecs = 0, n_ocs = 0, n_fill = 0, n_pin = 0, lat;
    logic [7:0] wq[$];
    logic [1:0] sq[$];
    logic [31:0] fd[4];
    ecb_bus_ctrl u_ecb_bus_ctrl (.CLK_I, .RST_N_I, .REQ_VALID_I, .REQ_ADDR_I, .REQ_SIZE_I,
        .REQ_WRITE_I, .REQ_WDATA_I, .REQ_FC_I, .REQ_FILL_I, .REQ_NOCACHE_I, .REQ_IFETCH_I,
        .REQ_READY_O, .DONE_O, .FAULT_O, .ALIGN_ERR_O, .RDATA_O, .FILL_VALID_O, .FILL_DATA_O,
        .FILL_IDX_O, .ADDR_O, .FC_O, .TRANSFER_SIZE_O, .RW_O, .ADDRESS_STROBE_N_O,
        .DATA_STROBE_N_O, .CYCLE_START_EARLY_N_O, .FIRST_OPERAND_CYCLE_START_N_O,
        .LINE_FILL_REQUEST_N_O, .DATA_O, .DATA_OE_N_O, .DATA_I, .PORT_WIDTH_ACK_N_I,
        .SYNC_CYCLE_END_N_I, .BUS_FAULT_N_I, .HALT_N_I, .LINE_FILL_GRANT_N_I, .NO_CACHE_IN_N_I);
    ecb_slave_model u_ecb_slave_model (.clk_i(CLK_I), .addr_i(ADDR_O), .as_n_i(ADDRESS_STROBE_N_O),
        .p_ack_n_i(p_ack), .p_sync_i(p_sync), .p_wait_i(p_wait), .p_gnt_i(p_gnt), .p_nc_i(p_nc),
        .p_fault_i(p_fault), .data_o(DATA_I), .ack_n_o(PORT_WIDTH_ACK_N_I),
        .sync_n_o(SYNC_CYCLE_END_N_I), .fault_n_o(BUS_FAULT_N_I), .halt_n_o(HALT_N_I),
        .gnt_n_o(LINE_FILL_GRANT_N_I), .nc_n_o(NO_CACHE_IN_N_I));
    always #5 CLK_I = ~CLK_I;
    // ----------------------------------------
    // Bus monitor and hang guard
    // ----------------------------------------
    // Sampled mid-cycle so the last beat of an operand is counted before its task checks
    always @(negedge CLK_I) begin
        if (DATA_STROBE_N_O !== ADDRESS_STROBE_N_O || (ADDRESS_STROBE_N_O === 1'b0 && DATA_OE_N_O !== RW_O))
            n_pin++;
        if (CYCLE_START_EARLY_N_O === 1'b0) begin
            n_ecs++;
            sq.push_back(TRANSFER_SIZE_O);
        end
        if (FIRST_OPERAND_CYCLE_START_N_O === 1'b0) n_ocs++;
        if (ADDRESS_STROBE_N_O === 1'b0 && as_q) wq.push_back(DATA_O[31:24]);
        as_q = (ADDRESS_STROBE_N_O !== 1'b0);
        if (FILL_VALID_O === 1'b1) begin
            fd[FILL_IDX_O] = FILL_DATA_O;
            n_fill++;
        end
        if (LINE_FILL_REQUEST_N_O === 1'b0) lfr_seen = 1;
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    function automatic logic [31:0] ew(input logic [31:0] a);
        return {a[7:0], a[7:0] + 8'h1, a[7:0] + 8'h2, a[7:0] + 8'h3};
    endfunction
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Fault is cleared for two clocks so the slave faults afresh
    task automatic mode(input logic [1:0] ak, input logic sy, input logic [3:0] w,
                        input logic [3:0] g, input logic nc, input logic [1:0] f);
        p_fault = 2'h0;
        repeat (2) @(posedge CLK_I);
        #1;
        {p_ack, p_sync, p_wait, p_gnt, p_nc, p_fault} = {ak, sy, w, g, nc, f};
    endtask
    task automatic op(input logic [31:0] a, input logic [1:0] sz, input logic wr, input logic fl,
                      input logic nc, input logic ifx);
        int n;
        n = 0;
        // Always start just after a rising edge, whatever the previous task left
        do begin
            @(posedge CLK_I);
            #1;
            n++;
        end while (REQ_READY_O !== 1'b1 && n < 100);
        {n_ecs, n_ocs, n_fill, lfr_seen} = '0;
        wq.delete();
        sq.delete();
        {REQ_ADDR_I, REQ_SIZE_I, REQ_WRITE_I, REQ_FILL_I, REQ_NOCACHE_I, REQ_IFETCH_I} = {a, sz, wr, fl, nc, ifx};
        REQ_VALID_I = 1;
        @(posedge CLK_I);
        #1;
        REQ_VALID_I = 0;
        lat = 0;
        while (DONE_O !== 1'b1 && FAULT_O !== 1'b1 && ALIGN_ERR_O !== 1'b1 && lat < 200) begin
            @(posedge CLK_I);
            #1;
            lat++;
        end
        // Pulses still stand here, and the monitor has seen the final clock
        @(negedge CLK_I);
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_async();
        for (int w = 1; w <= 3; w += 2) begin
            mode(2'h0, 0, w[3:0], 4'h0, 0, 2'h0);
            op(32'h100, SZ_LONG, 0, 0, 0, 0);
            chk("async latency", lat, w + 2);
            chk("async data", RDATA_O, ew(32'h100));
            chk("cycle starts", {n_ecs[15:0], n_ocs[15:0]}, 32'h00010001);
            chk("space code", FC_O, 3'h5);
        end
    endtask
    task automatic t_ports();
        mode(2'h1, 0, 4'h1, 4'h0, 0, 2'h0);
        op(32'h100, SZ_LONG, 0, 0, 0, 0);
        chk("16-bit cycles", {n_ecs[15:0], n_ocs[15:0]}, 32'h00020001);
        chk("16-bit data", RDATA_O, ew(32'h100));
        mode(2'h2, 0, 4'h1, 4'h0, 0, 2'h0);
        op(32'h100, SZ_LONG, 0, 0, 0, 0);
        chk("8-bit cycles", n_ecs, 4);
        chk("8-bit data", RDATA_O, ew(32'h100));
    endtask
    task automatic t_misalign();
        mode(2'h0, 0, 4'h1, 4'h0, 0, 2'h0);
        op(32'h101, SZ_LONG, 0, 0, 0, 0);
        chk("misaligned cycles", n_ecs, 2);
        chk("misaligned data", RDATA_O, ew(32'h101));
        chk("sizes left", {sq[0], sq[1]}, 4'h1);
    endtask
    task automatic t_sync();
        for (int w = 0; w <= 2; w += 2) begin
            mode(2'h3, 1, w[3:0], 4'h0, 0, 2'h0);
            op(32'h101, SZ_LONG, 0, 0, 0, 0);
            chk("sync latency", lat, 2 * (w + 2));
            chk("sync data", RDATA_O, ew(32'h101));
        end
    endtask
    task automatic t_burst();
        mode(2'h3, 1, 4'h0, 4'h4, 0, 2'h0);
        op(32'h200, SZ_LONG, 0, 1, 0, 0);
        chk("burst beats", n_fill, 4);
        for (int k = 0; k < 4; k++) chk("beat data", fd[k], ew(32'h200 + 4 * k));
        chk("burst one cycle", n_ecs, 1);
        chk("fill request", lfr_seen, 1);
        op(32'h200, SZ_LONG, 0, 0, 0, 0);
        chk("no burst unrequested", n_fill, 0);
        op(32'h200, SZ_LONG, 0, 1, 1, 0);
        chk("no request uncached", {lfr_seen, n_fill[3:0]}, 5'h0);
        for (int nc = 0; nc < 2; nc++) begin
            mode(2'h3, 1, 4'h0, 4'h2, nc[0], 2'h0);
            op(32'h200, SZ_LONG, 0, 1, 0, 0);
            chk("stopped burst", n_fill, 2);
        end
    endtask
    task automatic t_write();
        mode(2'h2, 0, 4'h1, 4'h0, 0, 2'h0);
        REQ_WDATA_I = 32'h11223344;
        op(32'h300, SZ_LONG, 1, 1, 0, 0);
        chk("write cycles", n_ecs, 4);
        for (int k = 0; k < 4; k++) begin
            chk("write lane", wq[k], 8'h11 * (k + 1));
            chk("write size", sq[k], (4 - k) & 3);
        end
        chk("no request on write", lfr_seen, 0);
    endtask
    task automatic t_fault();
        for (int s = 0; s < 2; s++) begin
            for (int f = 1; f <= 2; f++) begin
                mode(s ? 2'h3 : 2'h0, s[0], s ? 4'h0 : 4'h1, 4'h0, 0, f[1:0]);
                op(32'h104, SZ_LONG, 0, 0, 0, 0);
                chk("fault flag", FAULT_O, f == 1);
                if (f == 2) chk("rerun data", RDATA_O, ew(32'h104));
                if (f == 2) chk("rerun cycles", n_ecs, 2);
            end
        end
    endtask
    task automatic t_ifetch();
        mode(2'h0, 0, 4'h1, 4'h0, 0, 2'h0);
        op(32'h401, SZ_LONG, 0, 0, 0, 1);
        chk("odd fetch refused", {ALIGN_ERR_O, n_ecs[3:0]}, 5'h10);
        op(32'h402, SZ_LONG, 0, 0, 0, 1);
        chk("even fetch done", DONE_O, 1);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge CLK_I);
        #1;
        RST_N_I = 1;
        t_async();
        t_ports();
        t_misalign();
        t_sync();
        t_burst();
        t_write();
        t_fault();
        t_ifetch();
        chk("strobe and drive pins", n_pin, 0);
        finish_test();
    end
endmodule
